// ===== rtl/conv_port_defines.svh
// Purpose: offsets, fields, reset values and timing counts of the port
// Assumes: 40 MHz system clock
// Notes: byte addresses on Avalon-MM, one word per register
`ifndef CONV_PORT_DEFINES_SVH
`define CONV_PORT_DEFINES_SVH

`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_MASK 4'h8
`define OFS_RESULT 4'hC
`define REG_IDX_W 4

`define CTRL_FWORD_LSB 0
`define CTRL_FWORD_W 10
`define CTRL_SINC3_BIT 10
`define CTRL_CHOP_BIT 11
`define CTRL_RESET 12'h060

`define ST_DONE_BIT 0
`define ST_SYNC_BIT 1
`define ST_WRITE_BIT 2
`define ST_W 3

`define CLK_HZ 40000000
`define RATE_BASE_HZ 4800
`define CYC_PER_FWORD (`CLK_HZ / `RATE_BASE_HZ)
`define SETTLE_PERIODS 4
`define CHOP_FACTOR 4

`define COMM_W 8
`define COMM_RS_LSB 3
`define COMM_RS_W 3
`define COMM_READ_BIT 6
`define SREG_COMM 3'h0
`define SREG_STATUS 3'h1
`define SREG_MODE 3'h2
`define SREG_DATA 3'h3
`define SREG_W 24

`endif

// ===== rtl/conv_port_pkg.sv
// Purpose: shared types of the converter port
// Assumes: constants in conv_port_defines.svh
// Notes: none
`include "conv_port_defines.svh"
package conv_port_pkg;
	typedef enum logic [1:0] {
		SER_CMD = 2'b00,
		SER_WR = 2'b01,
		SER_RD = 2'b10
	} ser_state_t;

	typedef struct packed {
		logic chop;
		logic sinc3;
		logic [`CTRL_FWORD_W-1:0] fword;
	} filt_cfg_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
		logic sync_n;
	} pins_t;
endpackage : conv_port_pkg

// ===== rtl/conv_regfile.sv
// Purpose: small register store of the serial side
// Assumes: one write port, registered read
// Notes: read data from a flip-flop
`include "conv_port_defines.svh"
module conv_regfile (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic we_i,
	input wire logic [`COMM_RS_W-1:0] waddr_i,
	input wire logic [`SREG_W-1:0] wdata_i,
	input wire logic [`COMM_RS_W-1:0] raddr_i,
	output logic [`SREG_W-1:0] rdata_o
);
	logic [`SREG_W-1:0] mem_r [0:(1<<`COMM_RS_W)-1];

	genvar g;
	generate
		for (g = 0; g < (1<<`COMM_RS_W); g++) begin : g_word
			always_ff @(posedge ref_clk_i) begin
				if (reset_i)
					mem_r[g] <= '0;
				else if (we_i && waddr_i == g)
					mem_r[g] <= wdata_i;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			rdata_o <= '0;
		else
			rdata_o <= mem_r[raddr_i];
	end
endmodule : conv_regfile

// ===== rtl/conv_port.sv
// Purpose: sync, ready and serial port logic of a sigma-delta converter
// Assumes: serial pins sampled by ref_clk_i, 40 MHz
// Notes: Avalon-MM slave for host-side control and status
// Function
// - Low sync holds filter, filter control and calibration logic in reset.
// - Low sync also holds the modulator in reset.
// - Sync leaves the serial interface and its transfers working.
// - Sync going low returns a low ready indication to high.
// - Data-out/ready pin goes low when a conversion completes.
// - Unread result: pin returns high before the next update.
// - Bits change on sclk falling edge, sampled on rising edge.
// - Output shift register loads from any selected register on read.
// - Shifted-in bits go to the register chosen by select field.
// - Sinc4 or sinc3 filter, chopping on or off.
// - Output rate is 4800 Hz over the filter word with chop off, 1200 Hz over it with chop on.
// - Settling takes four output periods with sinc4, chop off.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`include "conv_port_defines.svh"
module conv_port (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [`REG_IDX_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	input wire logic sync_n_i,
	output logic dout_rdy_o,
	output logic dout_rdy_oe_o,
	output logic mod_reset_o,
	output logic filt_reset_o,
	output logic settled_o
);
	conv_port_pkg::pins_t meta_r;
	conv_port_pkg::pins_t pin_r;
	logic sclk_d_r;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta_r <= 4'hF;
			pin_r <= 4'hF;
			sclk_d_r <= 1'b1;
		end else begin
			meta_r <= '{sclk_i, cs_n_i, din_i, sync_n_i};
			pin_r <= meta_r;
			sclk_d_r <= pin_r.sclk;
		end
	end

	wire sel = !pin_r.cs_n;
	wire sclk_rise = sel && pin_r.sclk && !sclk_d_r;
	wire sclk_fall = sel && !pin_r.sclk && sclk_d_r;
	wire in_sync = !pin_r.sync_n;

	// Avalon slave: one wait cycle, then answer
	logic ack_r;
	logic [11:0] ctrl_r;
	logic [`ST_W-1:0] status_r;
	logic [`ST_W-1:0] mask_r;
	logic [`SREG_W-1:0] result_r;
	wire req = (avs_read_i || avs_write_i) && !ack_r;
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
	wire acc = (avs_read_i || avs_write_i) && ack_r;
	wire wr_ctrl = acc && avs_write_i && avs_address_i == `OFS_CTRL;
	wire wr_mask = acc && avs_write_i && avs_address_i == `OFS_MASK;
	wire rd_stat = acc && avs_read_i && avs_address_i == `OFS_STATUS;

	conv_port_pkg::filt_cfg_t cfg;
	assign cfg = conv_port_pkg::filt_cfg_t'(ctrl_r);

	// period is word times base step, four times that with chop on
	wire [`CTRL_FWORD_W-1:0] fword = (cfg.fword == '0) ? 10'h001 : cfg.fword;
	localparam int STEP = `CYC_PER_FWORD;
	wire [31:0] period_base = 32'(fword) * 32'(STEP);
	wire [31:0] period = cfg.chop ? period_base * `CHOP_FACTOR : period_base;
	wire [2:0] settle_n = cfg.sinc3 ? 3'h3 : 3'(`SETTLE_PERIODS);

	logic [31:0] cnt_r;
	logic [2:0] settle_r;
	logic [`SREG_W-1:0] sample_r;
	wire conv_done = (cnt_r >= period - 32'h1);

	// filter and calibration held in reset
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || in_sync) begin
			cnt_r <= '0;
			settle_r <= '0;
			sample_r <= '0;
		end else if (conv_done) begin
			cnt_r <= '0;
			sample_r <= sample_r + 24'h000001;
			if (settle_r != settle_n)
				settle_r <= settle_r + 3'h1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
	assign filt_reset_o = in_sync;
	assign mod_reset_o = in_sync;
	assign settled_o = (settle_r == settle_n);

	// Serial side state
	conv_port_pkg::ser_state_t st_r;
	logic [5:0] bit_r;
	logic [`SREG_W-1:0] sh_in_r;
	logic [`SREG_W-1:0] sh_out_r;
	logic [`COMM_RS_W-1:0] rsel_r;
	logic rdy_n_r;
	logic dout_r;
	logic rf_we;
	logic [`SREG_W-1:0] rf_rdata;

	function automatic logic [5:0] reg_len(input logic [`COMM_RS_W-1:0] rs);
		case (rs)
			`SREG_COMM: reg_len = 6'd8;
			`SREG_STATUS: reg_len = 6'd8;
			default: reg_len = 6'd24;
		endcase
	endfunction : reg_len

	wire [`COMM_W-1:0] comm_nxt = {sh_in_r[`COMM_W-2:0], pin_r.din};
	wire [`COMM_RS_W-1:0] rs_field = comm_nxt[`COMM_RS_LSB +: `COMM_RS_W];
	wire last_bit = (bit_r == reg_len(rsel_r) - 6'd1);
	wire rd_data = (st_r == conv_port_pkg::SER_RD) && rsel_r == `SREG_DATA;
	// source for the output shift register
	wire [`SREG_W-1:0] rd_src = (rsel_r == `SREG_DATA) ? result_r :
		(rsel_r == `SREG_STATUS) ? {16'h0000, rdy_n_r, 7'h00} : rf_rdata;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !sel) begin
			st_r <= conv_port_pkg::SER_CMD;
			bit_r <= '0;
			sh_in_r <= '0;
			rsel_r <= '0;
		end else if (sclk_rise) begin
			case (st_r)
				conv_port_pkg::SER_CMD: begin
					sh_in_r <= {sh_in_r[`SREG_W-2:0], pin_r.din};
					if (bit_r == 6'd7) begin
						bit_r <= '0;
						rsel_r <= rs_field;
						if (comm_nxt[`COMM_READ_BIT])
							st_r <= conv_port_pkg::SER_RD;
						else
							st_r <= conv_port_pkg::SER_WR;
					end else begin
						bit_r <= bit_r + 6'd1;
					end
				end
				conv_port_pkg::SER_WR, conv_port_pkg::SER_RD: begin
					sh_in_r <= {sh_in_r[`SREG_W-2:0], pin_r.din};
					bit_r <= last_bit ? 6'd0 : bit_r + 6'd1;
					if (last_bit)
						st_r <= conv_port_pkg::SER_CMD;
				end
				default: st_r <= conv_port_pkg::SER_CMD;
			endcase
		end
	end

	assign rf_we = sclk_rise && st_r == conv_port_pkg::SER_WR && last_bit;
	conv_regfile u_regfile (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.we_i(rf_we),
		.waddr_i(rsel_r),
		.wdata_i({sh_in_r[`SREG_W-2:0], pin_r.din}),
		.raddr_i(rsel_r),
		.rdata_o(rf_rdata)
	);

	wire left_aligned = (reg_len(rsel_r) == 6'd8);
	wire [`SREG_W-1:0] src_al = left_aligned ? {rd_src[7:0], 16'h0000} :
		rd_src;
	// First fall loads fresh: select and store read settle after command
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sh_out_r <= '0;
			dout_r <= 1'b1;
		end else if (st_r != conv_port_pkg::SER_RD) begin
			sh_out_r <= src_al;
			dout_r <= 1'b1;
		end else if (sclk_fall && bit_r == 6'd0) begin
			dout_r <= src_al[`SREG_W-1];
			sh_out_r <= {src_al[`SREG_W-2:0], 1'b0};
		end else if (sclk_fall) begin
			dout_r <= sh_out_r[`SREG_W-1];
			sh_out_r <= {sh_out_r[`SREG_W-2:0], 1'b0};
		end
	end

	// Ready flag and result latch
	wire read_done = sclk_rise && rd_data && last_bit;
	wire pre_update = (cnt_r == period - 32'h2) || period < 32'h2;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdy_n_r <= 1'b1;
			result_r <= '0;
		end else if (in_sync) begin
			rdy_n_r <= 1'b1;
		end else if (conv_done && !rd_data) begin
			rdy_n_r <= 1'b0;
			result_r <= sample_r;
		end else if (pre_update || read_done) begin
			rdy_n_r <= 1'b1;
		end
	end

	// pin released with chip select high
	assign dout_rdy_oe_o = sel;
	// falling edge serves as data interrupt
	assign dout_rdy_o = (st_r == conv_port_pkg::SER_RD) ? dout_r : rdy_n_r;

	// Interrupt status, read clears; set wins
	logic filt_q_r;
	wire done_ev = conv_done && !in_sync;
	wire sync_ev = in_sync && !filt_q_r;
	wire [`ST_W-1:0] ev = {rf_we, sync_ev, done_ev};
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ack_r <= 1'b0;
			ctrl_r <= `CTRL_RESET;
			mask_r <= '0;
			status_r <= '0;
			filt_q_r <= 1'b0;
			avs_readdata_o <= '0;
		end else begin
			ack_r <= req;
			filt_q_r <= in_sync;
			if (wr_ctrl)
				ctrl_r <= avs_writedata_i[11:0];
			if (wr_mask)
				mask_r <= avs_writedata_i[`ST_W-1:0];
			status_r <= (rd_stat ? '0 : status_r) | ev;
			if (req && avs_read_i) begin
				case (avs_address_i)
					`OFS_CTRL: avs_readdata_o <= {20'h00000, ctrl_r};
					`OFS_STATUS: avs_readdata_o <= {29'h0, status_r};
					`OFS_MASK: avs_readdata_o <= {29'h0, mask_r};
					`OFS_RESULT: avs_readdata_o <= {8'h00, result_r};
					default: avs_readdata_o <= '0;
				endcase
			end
		end
	end
	assign irq_o = |(status_r & mask_r);
endmodule : conv_port

// ===== test/conv_port_chk.sv
// Purpose: port checks of conv_port
// Assumes: one clock domain, sync reset
// Notes: bound to every conv_port
`include "conv_port_defines.svh"
module conv_port_chk (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [`REG_IDX_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic irq_o,
	input wire logic cs_n_i,
	input wire logic sync_n_i,
	input wire logic dout_rdy_o,
	input wire logic dout_rdy_oe_o,
	input wire logic mod_reset_o,
	input wire logic filt_reset_o,
	input wire logic settled_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	chk_filt_hold: assert property (!sync_n_i [*4] |-> filt_reset_o)
		else $error("filter not held");
	chk_mod_hold: assert property (!sync_n_i [*4] |-> mod_reset_o)
		else $error("modulator not held");
	chk_rdy_sync: assert property (
		$past(filt_reset_o) && filt_reset_o && !dout_rdy_oe_o |-> dout_rdy_o)
		else $error("ready low");
	chk_settle_clr: assert property (filt_reset_o |-> ##1 !settled_o)
		else $error("settled in sync");
	chk_pin_release: assert property (
		$stable(cs_n_i) [*4] |-> dout_rdy_oe_o == !cs_n_i) else $error("pin oe");
	chk_one_wait: assert property ($rose(avs_read_i || avs_write_i)
		|-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait");
	chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
		else $error("unmapped data");
	chk_irq_masked: assert property (avs_write_i && !avs_waitrequest_o
		&& avs_address_i == `OFS_MASK && avs_writedata_i[2:0] == 3'h0
		|=> !irq_o) else $error("irq not masked");
	cover property ($rose(irq_o));
	cover property ($rose(settled_o));
	cover property ($rose(filt_reset_o));
endmodule : conv_port_chk
bind conv_port conv_port_chk chk_u (.ref_clk_i, .reset_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
	.avs_waitrequest_o, .irq_o, .cs_n_i, .sync_n_i, .dout_rdy_o,
	.dout_rdy_oe_o, .mod_reset_o, .filt_reset_o, .settled_o);

// ===== test/conv_host_model.sv
// Purpose: host side of the serial port
// Assumes: 200 ns serial clock
// Notes: clock idles high outside frames
module conv_host_model (
	input wire logic ref_clk_i,
	input wire logic dout_rdy_i,
	input wire logic dout_rdy_oe_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pin;
	logic last_r = 1'b1;
	// Released pin toggles, never a stale bit
	assign pin = dout_rdy_oe_i ? dout_rdy_i : ~last_r;
	always @(posedge ref_clk_i) last_r <= pin;
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	task automatic half;
		repeat (4) @(posedge ref_clk_i);
	endtask : half
	// drive on fall, sample on rise
	task automatic xfer(input logic [31:0] tx, input int n,
		output logic [31:0] rx);
		rx = 32'h0;
		cs_n_o <= 1'b0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o <= 1'b0;
			din_o <= tx[i];
			half();
			rx = {rx[30:0], pin};
			sclk_o <= 1'b1;
			half();
		end
		cs_n_o <= 1'b1;
		half();
	endtask : xfer
	// ready fall used as data interrupt
	task automatic wait_rdy(output int k_fall, output int k_low);
		cs_n_o <= 1'b0;
		half();
		for (k_fall = 0; k_fall < 20000; k_fall++) begin
			@(posedge ref_clk_i);
			if (pin === 1'b0) break;
		end
		for (k_low = 0; k_low < 20000; k_low++) begin
			@(posedge ref_clk_i);
			if (pin === 1'b1) break;
		end
		cs_n_o <= 1'b1;
		half();
	endtask : wait_rdy
endmodule : conv_host_model

// ===== test/conv_port_tb.sv
// Purpose: self-checking bench of conv_port
// Assumes: filter word 1 keeps runs short
// Notes: read data checked off a queue
`include "conv_port_defines.svh"
module conv_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PER = `CYC_PER_FWORD;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic sync_n_i = 1'b1;
	logic [31:0] avs_readdata_o, rx;
	logic [31:0] seed = 32'h0000000A;
	logic avs_waitrequest_o, irq_o, sclk_i, cs_n_i, din_i, dout_rdy_o;
	logic dout_rdy_oe_o, mod_reset_o, filt_reset_o, settled_o;
	logic [31:0] modes[4] = '{32'hC01, 32'h801, 32'h401, 32'h001};
	logic [32:0] exp_q[$];
	int num_errors = 0;
	int checks_done = 0;
	int n;
	int n2;
	always #12.5 ref_clk_i = ~ref_clk_i;
	conv_port dut_u (.ref_clk_i, .reset_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
		.irq_o, .sclk_i, .cs_n_i, .din_i, .sync_n_i, .dout_rdy_o,
		.dout_rdy_oe_o, .mod_reset_o, .filt_reset_o, .settled_o);
	conv_host_model host_u (.ref_clk_i, .dout_rdy_i(dout_rdy_o),
		.dout_rdy_oe_i(dout_rdy_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
		.din_o(din_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	// Bit 32 of a note marks data not compared
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [32:0] e);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		if (!w) exp_q.push_back(e);
		do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : bus
	task automatic cnt(input logic s, output int k);
		for (k = 0; k < 40000; k++) begin
			@(posedge ref_clk_i);
			if ((s ? settled_o : irq_o) === 1'b1) break;
		end
	endtask : cnt
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	always @(posedge ref_clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
			if (!exp_q[0][32]) chk(avs_readdata_o === exp_q[0][31:0], "read");
			void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		@(posedge ref_clk_i);
		bus(0, `OFS_CTRL, 0, {21'h0, `CTRL_RESET});
		bus(0, 4'h2, 0, 33'h0);
		seed = lfsr(seed);
		bus(1, 4'h3, seed, 33'h0);
		foreach (modes[i]) begin
			bus(1, `OFS_CTRL, modes[i], 33'h0);
			bus(0, `OFS_CTRL, 0, {1'b0, modes[i]});
		end
		bus(1, `OFS_MASK, 32'h7, 33'h0);
		bus(0, `OFS_MASK, 0, 33'h7);
		$display("test regs done");
		bus(0, `OFS_STATUS, 0, {1'b1, 32'h0});
		sync_n_i <= 1'b0;
		seed = lfsr(seed);
		host_u.xfer({8'h10, seed[23:0]}, 32, rx);
		host_u.xfer({8'h50, 24'h0}, 32, rx);
		chk(rx[23:0] === seed[23:0], "mode readback");
		host_u.xfer({16'h0, 8'h48, 8'h0}, 16, rx);
		chk(rx[7] === 1'b1, "ready in sync");
		chk(filt_reset_o === 1'b1, "filter reset");
		chk(mod_reset_o === 1'b1, "modulator reset");
		chk(irq_o === 1'b1, "irq raised");
		bus(1, `OFS_MASK, 0, 33'h0);
		chk(irq_o === 1'b0, "irq masked");
		bus(0, `OFS_STATUS, 0, 33'h6);
		bus(0, `OFS_STATUS, 0, 33'h0);
		bus(1, `OFS_MASK, 32'h7, 33'h0);
		sync_n_i <= 1'b1;
		cnt(1, n);
		chk(n > 4 * PER - 8 && n < 4 * PER + 8, "settle");
		$display("test sync done");
		bus(0, `OFS_STATUS, 0, {1'b1, 32'h0});
		cnt(0, n);
		bus(0, `OFS_STATUS, 0, {1'b1, 32'h0});
		cnt(0, n);
		chk(n > PER - 12 && n < PER + 4, "period");
		host_u.xfer({16'h0, 8'h48, 8'h0}, 16, rx);
		chk(rx[7] === 1'b0, "ready low");
		host_u.xfer({8'h58, 24'h0}, 32, rx);
		host_u.xfer({16'h0, 8'h48, 8'h0}, 16, rx);
		chk(rx[7] === 1'b1, "ready after read");
		host_u.wait_rdy(n, n2);
		chk(n < PER + 4, "ready fall");
		chk(n2 > PER - 12 && n2 < PER, "unread release");
		$display("test rate done");
		give_verdict();
	end
endmodule : conv_port_tb
